/* File: repeater_status_indicator_logic.sv */
// Front-panel indicator and fault relay control of the fieldbus repeater
`timescale 1ns/100ps
module repeater_status_indicator_logic #(
    parameter int unsigned BLINK_HALF_CYCLES = status_pkg::BLINK_HALF_CYCLES,
    parameter int unsigned MAX_SEND_CYCLES = status_pkg::MAX_SEND_CYCLES,
    parameter int unsigned SPORADIC_HOLD_CYCLES = status_pkg::SPORADIC_HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_ok,
    input wire logic frame_done,
    input wire logic frame_is_token,
    input wire logic [status_pkg::RATE_W-1:0] frame_rate_code,
    input wire logic rate_lost,
    input wire logic slot_time_known,
    input wire logic ring_mode_port2,
    input wire logic ring_mode_port3,
    input wire logic rx_activity,
    input wire logic collision_detect,
    input wire logic sporadic_glitch,
    input wire logic line_fault,
    output logic sys_led_green,
    output logic sys_led_red,
    output logic electrical_port_indicator_yellow,
    output logic electrical_port_indicator_red,
    output logic fault_relay_closed
);
    blink_if bl();

    blink_gen #(
        .HALF_CYCLES(BLINK_HALF_CYCLES)
    ) u_blink (
        .clk(clk),
        .rst_n(rst_n),
        .bl(bl)
    );

    function automatic logic rate_is_standard(input logic [status_pkg::RATE_W-1:0] code);
        rate_is_standard = (code <= status_pkg::RATE_CODE_MAX_STD);
    endfunction

    // Rate identification
    logic rate_known_reg;
    logic rate_known_next;

    always_comb begin
        rate_known_next = rate_known_reg;
        if (rate_lost) begin
            rate_known_next = 1'b0;
        end else if (frame_done) begin
            if (!rate_is_standard(frame_rate_code)) begin
                rate_known_next = 1'b0; // see R04
            end else if (!frame_is_token) begin
                rate_known_next = 1'b1; // see R03
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_known_reg <= 1'b0;
        end else begin
            rate_known_reg <= rate_known_next;
        end
    end

    // Maximum send time watchdog on the segment
    logic [status_pkg::CNT_W-1:0] send_cnt_reg;
    logic send_over_reg;

    always_ff @(posedge clk or negedge rst_n) begin // see R09
        if (!rst_n) begin
            send_cnt_reg <= '0;
            send_over_reg <= 1'b0;
        end else if (!rx_activity) begin
            send_cnt_reg <= '0;
            send_over_reg <= 1'b0;
        end else if (send_cnt_reg >= MAX_SEND_CYCLES[status_pkg::CNT_W-1:0] - 1'b1) begin
            send_over_reg <= 1'b1;
        end else begin
            send_cnt_reg <= send_cnt_reg + 1'b1;
        end
    end

    // Sporadic interference keeps the port flashing for a hold time
    logic [status_pkg::CNT_W-1:0] spor_cnt_reg;
    logic spor_active;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spor_cnt_reg <= '0;
        end else if (sporadic_glitch) begin
            spor_cnt_reg <= SPORADIC_HOLD_CYCLES[status_pkg::CNT_W-1:0];
        end else if (spor_cnt_reg != '0) begin
            spor_cnt_reg <= spor_cnt_reg - 1'b1;
        end
    end

    assign spor_active = (spor_cnt_reg != '0);

    // Permanent interference: collision, stuck transmitter or line fault
    logic perm_fault;
    assign perm_fault = collision_detect || send_over_reg || line_fault; // see R08

    // System indicator state
    status_pkg::sys_state_t sys_state;
    logic ring_mismatch;
    assign ring_mismatch = ring_mode_port2 ^ ring_mode_port3;

    always_comb begin
        if (!supply_ok) begin
            sys_state = status_pkg::SYS_OFF;
        end else if (!rate_known_reg) begin
            sys_state = status_pkg::SYS_RATE_SEARCH; // see R02
        end else if (!slot_time_known || ring_mismatch) begin
            sys_state = status_pkg::SYS_SLOT_SEARCH; // see R05, R06
        end else begin
            sys_state = status_pkg::SYS_RUN; // see R01
        end
    end

    logic sys_green_next;
    logic sys_red_next;

    always_comb begin
        case (sys_state)
            status_pkg::SYS_RATE_SEARCH: begin
                sys_green_next = 1'b0;
                sys_red_next = bl.phase; // see R02
            end
            status_pkg::SYS_SLOT_SEARCH: begin
                sys_green_next = ~bl.phase; // see R05, R12
                sys_red_next = bl.phase;
            end
            status_pkg::SYS_RUN: begin
                sys_green_next = 1'b1; // see R01
                sys_red_next = 1'b0;
            end
            default: begin
                sys_green_next = 1'b0;
                sys_red_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_led_green <= 1'b0;
            sys_led_red <= 1'b0;
        end else begin
            sys_led_green <= sys_green_next;
            sys_led_red <= sys_red_next;
        end
    end

    // Electrical port indicator: red overrides yellow
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            electrical_port_indicator_yellow <= 1'b0;
            electrical_port_indicator_red <= 1'b0;
        end else if (perm_fault) begin
            electrical_port_indicator_yellow <= 1'b0;
            electrical_port_indicator_red <= 1'b1; // see R08, R10
        end else if (spor_active) begin
            electrical_port_indicator_yellow <= 1'b0;
            electrical_port_indicator_red <= bl.phase; // see R10
        end else begin
            electrical_port_indicator_yellow <= rx_activity; // see R07
            electrical_port_indicator_red <= 1'b0;
        end
    end

    // Relay opens on any signalled fault; rate or slot search is no fault
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_relay_closed <= 1'b0;
        end else begin
            fault_relay_closed <= supply_ok && !perm_fault && !spor_active; // see R11
        end
    end
endmodule

/* File: status_pkg.sv */
// Constants for the repeater status indicator logic
// Notes on behaviour
// R01: Bit rate and slot time identified and supply healthy: system indicator steady green, relay closed.
// R02: Bit rate not identified: system indicator flashes red, relay not opened for this.
// R03: Token frames alone never identify the rate; other traffic is needed.
// R04: Only standard fieldbus rates identify; nonstandard traffic keeps red flashing.
// R05: Rate known, slot time unknown: system indicator alternates red and green, no fault.
// R06: Ring mode set on only one optical port also gives red/green alternation.
// R07: Segment receive activity lights port indicator yellow, otherwise off, no fault.
// R08: Simultaneous transmit with another subscriber: port indicator red, relay opened.
// R09: Subscriber transmit longer than maximum send time is permanent interference.
// R10: Sporadic interference flashes port indicator red; permanent holds it steady red.
// R11: Relay open on any fault, closed when fault free, so power loss reads as fault.
// R12: Flashing toggles at fixed visible rate; red and green phases equal length.
package status_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
    // Half period of every flashing indication
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * CYCLES_PER_MS;
    // Longest continuous transmission of one subscriber before it counts as stuck
    localparam int unsigned MAX_SEND_MS = 100;
    localparam int unsigned MAX_SEND_CYCLES = MAX_SEND_MS * CYCLES_PER_MS;
    // How long one sporadic interference event keeps the red flashing alive
    localparam int unsigned SPORADIC_HOLD_MS = 1000;
    localparam int unsigned SPORADIC_HOLD_CYCLES = SPORADIC_HOLD_MS * CYCLES_PER_MS;
    localparam int unsigned CNT_W = 32;
    // Rate codes from the baud detector; standard rates occupy codes 0 to 9
    localparam int unsigned RATE_W = 4;
    localparam logic [3:0] RATE_CODE_MAX_STD = 4'h9;
    // System indicator states
    typedef enum logic [1:0] {
        SYS_OFF = 2'b00,
        SYS_RATE_SEARCH = 2'b01,
        SYS_SLOT_SEARCH = 2'b10,
        SYS_RUN = 2'b11
    } sys_state_t;
endpackage

/* File: blink_if.sv */
// Flash timing carried from the blink generator to the indicator logic
`timescale 1ns/100ps
interface blink_if;
    logic phase;
    logic tick;
    modport src (output phase, output tick);
    modport snk (input phase, input tick);
endinterface

/* File: blink_gen.sv */
// Divider that makes the flash phase and a one-cycle phase-change pulse
`timescale 1ns/100ps
module blink_gen #(
    parameter int unsigned HALF_CYCLES = status_pkg::BLINK_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    blink_if.src bl
);
    logic [status_pkg::CNT_W-1:0] cnt_reg;
    logic phase_reg;
    logic tick_reg;

    // Equal-length phases from one terminal count
    always_ff @(posedge clk or negedge rst_n) begin // see R12
        if (!rst_n) begin
            cnt_reg <= '0;
            phase_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else if (cnt_reg >= HALF_CYCLES[status_pkg::CNT_W-1:0] - 1'b1) begin
            cnt_reg <= '0;
            phase_reg <= ~phase_reg;
            tick_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    assign bl.phase = phase_reg;
    assign bl.tick = tick_reg;
endmodule

/* File: status_props.sv */
// Port assertions for the repeater status indicator logic
`timescale 1ns/100ps
module status_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_ok,
    input wire logic frame_done,
    input wire logic [status_pkg::RATE_W-1:0] frame_rate_code,
    input wire logic rate_lost,
    input wire logic rx_activity,
    input wire logic collision_detect,
    input wire logic sporadic_glitch,
    input wire logic line_fault,
    input wire logic sys_led_green,
    input wire logic sys_led_red,
    input wire logic electrical_port_indicator_yellow,
    input wire logic electrical_port_indicator_red,
    input wire logic fault_relay_closed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_leds_exclusive: assert property (!(sys_led_green && sys_led_red))
        else $error("system red and green lit together");
    a_supply_dark: assert property (!supply_ok |=>
        !sys_led_green && !sys_led_red && !fault_relay_closed) else $error("supply loss");
    a_rate_cleared: assert property ((frame_done && frame_rate_code > 4'h9)
        || rate_lost |-> ##2 !sys_led_green) else $error("green without rate");
    a_yellow_cause: assert property (electrical_port_indicator_yellow |->
        $past(rx_activity)) else $error("yellow without activity");
    a_collision_red: assert property (collision_detect |=>
        electrical_port_indicator_red && !fault_relay_closed) else $error("collision");
    a_line_steady: assert property (line_fault |=> electrical_port_indicator_red
        && !electrical_port_indicator_yellow && !fault_relay_closed) else $error("line");
    a_relay_cause: assert property (fault_relay_closed |-> $past(supply_ok)
        && !$past(collision_detect) && !$past(line_fault)) else $error("relay closed");
    a_glitch_relay: assert property (sporadic_glitch |->
        ##3 !fault_relay_closed) else $error("glitch left relay closed");
    cover property (sys_led_green && !sys_led_red);
    cover property (sys_led_green ##4 sys_led_red);
    cover property (electrical_port_indicator_yellow ##1 electrical_port_indicator_red);
endmodule
bind repeater_status_indicator_logic status_props props (.*);

/* File: panel_model.sv */
// Panel observer measuring how long an indicator stays lit per flash
`timescale 1ns/100ps
module panel_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic led,
    output int unsigned run_len
);
    int unsigned cnt_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 0;
            run_len <= 0;
        end else if (led) begin
            cnt_reg <= cnt_reg + 1;
        end else begin
            if (cnt_reg != 0) run_len <= cnt_reg;
            cnt_reg <= 0;
        end
    end
endmodule

/* File: repeater_status_indicator_logic_test.sv */
// Self-checking bench for the repeater status indicator logic
`timescale 1ns/100ps
module repeater_status_indicator_logic_test;
    logic clk = 0, rst_n = 0, supply_ok = 1, frame_done = 0, frame_is_token = 0;
    logic rate_lost = 0, slot_time_known = 0, ring_mode_port2 = 0, ring_mode_port3 = 0;
    logic rx_activity = 0, collision_detect = 0, sporadic_glitch = 0, line_fault = 0;
    logic [status_pkg::RATE_W-1:0] frame_rate_code = 4'h0;
    logic sys_led_green, sys_led_red, electrical_port_indicator_yellow;
    logic electrical_port_indicator_red, fault_relay_closed, g;
    int n_fail = 0, check_count = 0;
    int unsigned red_run;
    repeater_status_indicator_logic #(.BLINK_HALF_CYCLES(4), .MAX_SEND_CYCLES(20),
        .SPORADIC_HOLD_CYCLES(16)) dut (.*);
    panel_model pm (.clk(clk), .rst_n(rst_n), .led(sys_led_red), .run_len(red_run));
    initial forever #50 clk = ~clk;
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task frame(input logic tok, input logic [3:0] code);
        frame_done = 1;
        frame_is_token = tok;
        frame_rate_code = code;
        step(1);
        frame_done = 0;
        step(2);
    endtask
    task t_system;
        frame(1, 4'h6);
        chk("green token", 0, sys_led_green);
        frame(0, 4'hC);
        chk("green nonstd", 0, sys_led_green);
        chk("red half", 1, red_run == 4);
        chk("relay", 1, fault_relay_closed);
        frame(0, 4'h6);
        g = sys_led_green;
        chk("alternate", 1, sys_led_green ^ sys_led_red);
        step(4);
        chk("alt phase", ~g, sys_led_green);
        slot_time_known = 1;
        step(2);
        chk("green run", 1, sys_led_green & ~sys_led_red);
        ring_mode_port2 = 1;
        step(2);
        chk("ring", 1, sys_led_green ^ sys_led_red);
        ring_mode_port2 = 0;
        supply_ok = 0;
        step(2);
        chk("relay off", 0, fault_relay_closed | sys_led_green);
        supply_ok = 1;
        step(2);
        $display("t_system done");
    endtask
    task t_codes;
        for (int c = 0; c < 16; c++) begin
            rate_lost = 1;
            step(1);
            rate_lost = 0;
            frame(0, 4'(c));
            chk("green code", c < 10, sys_led_green);
        end
        $display("t_codes done");
    endtask
    task t_port;
        rx_activity = 1;
        step(2);
        chk("yellow", 1, electrical_port_indicator_yellow & fault_relay_closed);
        step(22);
        chk("send over", 1, electrical_port_indicator_red & ~fault_relay_closed);
        rx_activity = 0;
        step(3);
        chk("port idle", 0, electrical_port_indicator_red | electrical_port_indicator_yellow);
        collision_detect = 1;
        step(2);
        chk("collision", 1, electrical_port_indicator_red & ~fault_relay_closed);
        collision_detect = 0;
        sporadic_glitch = 1;
        step(1);
        sporadic_glitch = 0;
        step(3);
        g = electrical_port_indicator_red;
        step(4);
        chk("glitch flash", ~g, electrical_port_indicator_red);
        chk("glitch relay", 0, fault_relay_closed);
        step(20);
        chk("relay back", 1, fault_relay_closed);
        line_fault = 1;
        step(6);
        chk("steady red", 1, electrical_port_indicator_red);
        line_fault = 0;
        $display("t_port done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        end_of_test;
    end
    initial begin
        step(8);
        rst_n = 1;
        step(20);
        t_system;
        t_codes;
        t_port;
        end_of_test;
    end
endmodule
